// File: shared/csig_pkg.sv
package csig_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_KHZ = 25000;
    localparam int WAIT_EXT_MIN_US = 30;
    localparam int WAIT_EXT_MAX_US = 300;
    // least time rounds up, longest time rounds down
    localparam int WAIT_EXT_MIN_CYC = (WAIT_EXT_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int WAIT_EXT_MAX_CYC = (WAIT_EXT_MAX_US * CLK_KHZ) / 1000;
    // power settle and one memory clear pass, in clock cycles
    localparam int PWR_CYC = 32;
    localparam int CLEAR_CYC = 64;

    // ==========================================================
    // widths, field positions, reset values
    localparam int CNT_W = 13;
    localparam int MODE_W = 3;
    localparam int SYNC_W = 6;
    localparam int SYNC_CLEAR_N = 0;
    localparam int SYNC_INIT = 1;
    localparam int SYNC_DONE = 2;
    localparam int SYNC_MODE_LSB = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 6'h00;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
    localparam int MODE_MASTER_BIT = 0;
    localparam logic MODE_MASTER_LVL = 1'b0;

    typedef logic [CNT_W-1:0] csig_cnt_t;

    // ==========================================================
    // sequencer states
    typedef enum logic [3:0] {
        ST_PWR        = 4'h0,
        ST_CLEAR      = 4'h1,
        ST_CLEAR_LAST = 4'h2,
        ST_WAIT       = 4'h3,
        ST_WAIT_EXT   = 4'h4,
        ST_CONFIG     = 4'h5,
        ST_ERROR      = 4'h6,
        ST_DONE_WAIT  = 4'h7,
        ST_ACTIVE     = 4'h8
    } csig_state_e;
endpackage

// File: shared/csig_pin_if.sv
`timescale 1ns/1ns
interface csig_pin_if;
    logic clear_n;
    logic init_lvl;
    logic done_lvl;
    logic [csig_pkg::MODE_W-1:0] mode;
    modport sync_mp (output clear_n, output init_lvl, output done_lvl, output mode);
    modport core_mp (input clear_n, input init_lvl, input done_lvl, input mode);
endinterface

// File: rtl/csig_sync.sv
`timescale 1ns/1ns
module csig_sync (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // raw pad levels
    input wire logic [csig_pkg::SYNC_W-1:0] raw_in,
    // filtered levels
    csig_pin_if.sync_mp pins
);
    // ==========================================================
    // three-stage synchroniser; a level counts once stages two and three agree
    logic [csig_pkg::SYNC_W-1:0] ff1;
    logic [csig_pkg::SYNC_W-1:0] ff2;
    logic [csig_pkg::SYNC_W-1:0] ff3;
    logic [csig_pkg::SYNC_W-1:0] lvl;
    logic [csig_pkg::SYNC_W-1:0] next_lvl;

    genvar i;
    generate
        for (i = 0; i < csig_pkg::SYNC_W; i++) begin : g_bit
            always_comb begin
                next_lvl[i] = lvl[i];
                if (ff2[i] == ff3[i]) begin
                    next_lvl[i] = ff3[i];
                end
            end
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    ff1[i] <= csig_pkg::SYNC_RST[i];
                    ff2[i] <= csig_pkg::SYNC_RST[i];
                    ff3[i] <= csig_pkg::SYNC_RST[i];
                    lvl[i] <= csig_pkg::SYNC_RST[i];
                end else if (ce_in) begin
                    ff1[i] <= raw_in[i];
                    ff2[i] <= ff1[i];
                    ff3[i] <= ff2[i];
                    lvl[i] <= next_lvl[i];
                end
            end
        end
    endgenerate

    assign pins.clear_n = lvl[csig_pkg::SYNC_CLEAR_N];
    assign pins.init_lvl = lvl[csig_pkg::SYNC_INIT];
    assign pins.done_lvl = lvl[csig_pkg::SYNC_DONE];
    assign pins.mode = lvl[csig_pkg::SYNC_MODE_LSB +: csig_pkg::MODE_W];
endmodule

// File: rtl/csig_top.sv
`timescale 1ns/1ns
module csig_top #(
    parameter int WAIT_EXT_CYC = csig_pkg::WAIT_EXT_MIN_CYC,
    parameter int WAIT_EXT_MAX_CYC = csig_pkg::WAIT_EXT_MAX_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // pad inputs
    input wire logic clear_n_in,
    input wire logic init_pin_in,
    input wire logic done_pin_in,
    input wire logic [csig_pkg::MODE_W-1:0] mode_select_in,
    input wire logic tdi_pin_in,
    input wire logic tck_pin_in,
    input wire logic tms_pin_in,
    // configuration engine
    input wire logic cfg_error_in,
    input wire logic cfg_loaded_in,
    input wire logic scan_cell_instance_in,
    // user drive for the shared pins
    input wire logic user_hi_out_in,
    input wire logic user_hi_oe_in,
    input wire logic user_lo_out_in,
    input wire logic user_lo_oe_in,
    input wire logic user_init_out_in,
    input wire logic user_init_oe_in,
    // status pins
    output logic cfg_pending_hi_out,
    output logic cfg_pending_hi_oe_out,
    output logic cfg_pending_lo_n_out,
    output logic cfg_pending_lo_n_oe_out,
    output logic init_pin_out,
    output logic init_pin_oe_out,
    output logic done_pin_out,
    output logic done_pin_oe_out,
    // sequencer status
    output logic [csig_pkg::MODE_W-1:0] cfg_mode_out,
    output logic master_mode_out,
    output logic config_run_out,
    output logic io_active_out,
    output logic scan_enable_out,
    // test pins as user inputs
    output logic tdi_user_out,
    output logic tck_user_out,
    output logic tms_user_out
);
    // ==========================================================
    // pad synchronisers
    csig_pin_if pins ();

    csig_sync u_sync (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        .raw_in     ({mode_select_in, done_pin_in, init_pin_in, clear_n_in}),
        .pins       (pins.sync_mp)
    );

    // ==========================================================
    // sequencer
    csig_pkg::csig_state_e state;
    csig_pkg::csig_state_e next_state;
    csig_pkg::csig_cnt_t cnt;
    csig_pkg::csig_cnt_t next_cnt;
    logic [csig_pkg::MODE_W-1:0] next_mode;
    logic next_master;

    localparam csig_pkg::csig_cnt_t PWR_LAST = csig_pkg::csig_cnt_t'(csig_pkg::PWR_CYC - 1);
    localparam csig_pkg::csig_cnt_t CLR_LAST = csig_pkg::csig_cnt_t'(csig_pkg::CLEAR_CYC - 1);
    localparam csig_pkg::csig_cnt_t EXT_LAST = csig_pkg::csig_cnt_t'(WAIT_EXT_CYC - 1);

    always_comb begin
        next_state = state;
        next_cnt = cnt + 13'h0001;
        next_mode = cfg_mode_out;
        next_master = master_mode_out;
        unique case (state)
            csig_pkg::ST_PWR: begin
                if (cnt == PWR_LAST) begin
                    next_state = csig_pkg::ST_CLEAR;
                    next_cnt = 13'h0000;
                end
            end
            csig_pkg::ST_CLEAR: begin
                // the release must still stand at the pass end, a short blip starts another pass
                if (cnt == CLR_LAST) begin
                    next_cnt = 13'h0000;
                    if (pins.clear_n) begin
                        next_state = csig_pkg::ST_CLEAR_LAST;
                    end
                end
            end
            csig_pkg::ST_CLEAR_LAST: begin
                if (cnt == CLR_LAST) begin
                    next_state = csig_pkg::ST_WAIT;
                    next_cnt = 13'h0000;
                end
            end
            csig_pkg::ST_WAIT: begin
                next_cnt = 13'h0000;
                // init is open drain: any party holding it low keeps us here
                if (pins.init_lvl) begin
                    next_mode = pins.mode;
                    next_master = (pins.mode[csig_pkg::MODE_MASTER_BIT]
                                   == csig_pkg::MODE_MASTER_LVL);
                    next_state = next_master ? csig_pkg::ST_WAIT_EXT : csig_pkg::ST_CONFIG;
                end
            end
            csig_pkg::ST_WAIT_EXT: begin
                if (cnt == EXT_LAST) begin
                    next_state = csig_pkg::ST_CONFIG;
                    next_cnt = 13'h0000;
                end
            end
            csig_pkg::ST_CONFIG: begin
                next_cnt = 13'h0000;
                if (cfg_error_in) begin
                    next_state = csig_pkg::ST_ERROR;
                end else if (cfg_loaded_in) begin
                    next_state = csig_pkg::ST_DONE_WAIT;
                end
            end
            csig_pkg::ST_ERROR: begin
                next_cnt = 13'h0000;
            end
            csig_pkg::ST_DONE_WAIT: begin
                next_cnt = 13'h0000;
                if (pins.done_lvl) begin
                    next_state = csig_pkg::ST_ACTIVE;
                end
            end
            csig_pkg::ST_ACTIVE: begin
                next_cnt = 13'h0000;
            end
            default: begin
                next_state = csig_pkg::ST_PWR;
                next_cnt = 13'h0000;
            end
        endcase
        // clear low restarts a pass from anywhere but power settling and a clear pass before its last cycle
        if (!pins.clear_n && state != csig_pkg::ST_PWR
            && !(state == csig_pkg::ST_CLEAR && cnt != CLR_LAST)) begin
            next_state = csig_pkg::ST_CLEAR;
            next_cnt = 13'h0000;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state <= csig_pkg::ST_PWR;
            cnt <= 13'h0000;
            cfg_mode_out <= csig_pkg::MODE_RST;
            master_mode_out <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            cnt <= next_cnt;
            cfg_mode_out <= next_mode;
            master_mode_out <= next_master;
        end
    end

    // ==========================================================
    // pin drive, decoded from the next state so pins move with it
    logic next_hi;
    logic next_hi_oe;
    logic next_lo;
    logic next_lo_oe;
    logic next_init;
    logic next_init_oe;
    logic next_done_oe;
    logic next_active;

    always_comb begin
        next_active = (next_state == csig_pkg::ST_ACTIVE);
        next_hi = 1'b1;
        next_hi_oe = 1'b1;
        next_lo = 1'b0;
        next_lo_oe = 1'b1;
        next_init = 1'b0;
        next_init_oe = (next_state == csig_pkg::ST_PWR)
                       || (next_state == csig_pkg::ST_CLEAR)
                       || (next_state == csig_pkg::ST_CLEAR_LAST)
                       || (next_state == csig_pkg::ST_ERROR);
        next_done_oe = !(next_state == csig_pkg::ST_DONE_WAIT || next_active);
        if (next_active) begin
            next_hi = user_hi_out_in;
            next_hi_oe = user_hi_oe_in;
            next_lo = user_lo_out_in;
            next_lo_oe = user_lo_oe_in;
            next_init = user_init_out_in;
            next_init_oe = user_init_oe_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            cfg_pending_hi_out <= 1'b1;
            cfg_pending_hi_oe_out <= 1'b1;
            cfg_pending_lo_n_out <= 1'b0;
            cfg_pending_lo_n_oe_out <= 1'b1;
            init_pin_out <= 1'b0;
            init_pin_oe_out <= 1'b1;
            done_pin_oe_out <= 1'b1;
            io_active_out <= 1'b0;
        end else if (ce_in) begin
            cfg_pending_hi_out <= next_hi;
            cfg_pending_hi_oe_out <= next_hi_oe;
            cfg_pending_lo_n_out <= next_lo;
            cfg_pending_lo_n_oe_out <= next_lo_oe;
            init_pin_out <= next_init;
            init_pin_oe_out <= next_init_oe;
            done_pin_oe_out <= next_done_oe;
            io_active_out <= next_active;
        end
    end

    // done is open drain: only ever pulled low
    assign done_pin_out = 1'b0;
    assign config_run_out = (state == csig_pkg::ST_CONFIG);

    // ==========================================================
    // test pins: pad-direct path, no register in the way by design
    logic scan_off;
    assign scan_off = io_active_out && !scan_cell_instance_in;
    assign scan_enable_out = !scan_off;
    assign tdi_user_out = scan_off ? tdi_pin_in : 1'b0;
    assign tck_user_out = scan_off ? tck_pin_in : 1'b0;
    assign tms_user_out = scan_off ? tms_pin_in : 1'b0;

    // ==========================================================
    // checks
    property p_hi_pending;
        @(posedge clk_sys_in) disable iff (srst_in)
        !io_active_out |-> (cfg_pending_hi_out && cfg_pending_hi_oe_out);
    endproperty
    a_hi_pending: assert property (p_hi_pending) else $error("high pending not driven");

    property p_lo_pending;
        @(posedge clk_sys_in) disable iff (srst_in)
        !io_active_out |-> (!cfg_pending_lo_n_out && cfg_pending_lo_n_oe_out);
    endproperty
    a_lo_pending: assert property (p_lo_pending) else $error("low pending not driven");

    property p_init_clear;
        @(posedge clk_sys_in) disable iff (srst_in)
        (state == csig_pkg::ST_PWR || state == csig_pkg::ST_CLEAR
         || state == csig_pkg::ST_CLEAR_LAST)
        |-> (init_pin_oe_out && !init_pin_out);
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("init not low in clear");

    property p_wait_hold;
        @(posedge clk_sys_in) disable iff (srst_in)
        (ce_in && state == csig_pkg::ST_WAIT && !pins.init_lvl)
        |=> (state == csig_pkg::ST_WAIT || state == csig_pkg::ST_CLEAR);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("left wait with init low");

    property p_wait_ext;
        @(posedge clk_sys_in) disable iff (srst_in)
        ($past(state) == csig_pkg::ST_WAIT_EXT && state == csig_pkg::ST_CONFIG)
        |-> ($past(cnt) == EXT_LAST && WAIT_EXT_CYC >= csig_pkg::WAIT_EXT_MIN_CYC
             && WAIT_EXT_CYC <= WAIT_EXT_MAX_CYC);
    endproperty
    a_wait_ext: assert property (p_wait_ext) else $error("master wait length wrong");

    property p_error;
        @(posedge clk_sys_in) disable iff (srst_in)
        (ce_in && state == csig_pkg::ST_CONFIG && cfg_error_in && pins.clear_n)
        |=> (init_pin_oe_out && !init_pin_out) [*2];
    endproperty
    a_error: assert property (p_error) else $error("error not shown on init");

    property p_init_user;
        @(posedge clk_sys_in) disable iff (srst_in)
        (ce_in && state == csig_pkg::ST_ACTIVE && pins.clear_n)
        |=> (init_pin_oe_out == $past(user_init_oe_in));
    endproperty
    a_init_user: assert property (p_init_user) else $error("init not user after active");

    property p_scan_off;
        @(posedge clk_sys_in) disable iff (srst_in)
        (io_active_out && !scan_cell_instance_in) |-> (!scan_enable_out && tck_user_out == tck_pin_in);
    endproperty
    a_scan_off: assert property (p_scan_off) else $error("scan not released");

    property p_last_clear;
        @(posedge clk_sys_in) disable iff (srst_in)
        (ce_in && state == csig_pkg::ST_CLEAR_LAST && cnt == CLR_LAST && pins.clear_n)
        |=> (state == csig_pkg::ST_WAIT && !init_pin_oe_out);
    endproperty
    a_last_clear: assert property (p_last_clear) else $error("final clear not to wait");

    property p_mode_hold;
        @(posedge clk_sys_in) disable iff (srst_in)
        (state == csig_pkg::ST_CONFIG && $past(state) == csig_pkg::ST_CONFIG) |-> $stable(cfg_mode_out);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed in config");

    property p_done_hold;
        @(posedge clk_sys_in) disable iff (srst_in)
        (ce_in && state == csig_pkg::ST_DONE_WAIT && !pins.done_lvl) |=> !io_active_out;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("active despite done low");

    property p_no_conflict;
        @(posedge clk_sys_in) disable iff (srst_in)
        io_active_out |-> (state == csig_pkg::ST_ACTIVE && !done_pin_oe_out);
    endproperty
    a_no_conflict: assert property (p_no_conflict) else $error("pins disagree with state");
endmodule

// File: dv/csig_ctrl_model.sv
`timescale 1ns/1ns
// ==========================================================
// far-side controller: open-drain init and done wires with pull-ups, clear request
module csig_ctrl_model (
    // commands from the bench
    input wire logic hold_init_in,
    input wire logic hold_done_in,
    input wire logic clear_req_in,
    // device drive
    input wire logic dev_init_out_in,
    input wire logic dev_init_oe_in,
    input wire logic dev_done_out_in,
    input wire logic dev_done_oe_in,
    // wire levels
    output logic init_wire_out,
    output logic done_wire_out,
    output logic clear_n_out
);
    // pull-up wins only while nobody sinks the wire
    assign init_wire_out = !(dev_init_oe_in && !dev_init_out_in) && !hold_init_in;
    assign done_wire_out = !(dev_done_oe_in && !dev_done_out_in) && !hold_done_in;
    assign clear_n_out = !clear_req_in;
endmodule

// File: dv/test_config_status_signalling.sv
`timescale 1ns/1ns
module test_config_status_signalling;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [2:0] mode_select_in = 3'h0;
    logic tdi_pin_in = 1'b0, tck_pin_in = 1'b0, tms_pin_in = 1'b0;
    logic cfg_error_in = 1'b0, cfg_loaded_in = 1'b0, scan_cell_instance_in = 1'b0;
    logic user_hi_out_in = 1'b0, user_hi_oe_in = 1'b0, user_lo_out_in = 1'b0;
    logic user_lo_oe_in = 1'b0, user_init_out_in = 1'b0, user_init_oe_in = 1'b0;
    logic hold_init = 1'b0, hold_done = 1'b0, clear_req = 1'b0;
    logic init_wire, done_wire, clear_n_pad;
    logic hi_o, hi_oe, lo_o, lo_oe, init_o, init_oe, done_o, done_oe;
    logic [2:0] mode_o;
    logic master_o, run_o, act_o, scan_o, tdi_o, tck_o, tms_o;
    int err_count = 0;
    int checks_done = 0;
    int n;
    int exp_modes[$];
    logic [5:0] u;

    csig_top i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in),
        .clear_n_in(clear_n_pad), .init_pin_in(init_wire), .done_pin_in(done_wire),
        .mode_select_in(mode_select_in), .tdi_pin_in(tdi_pin_in), .tck_pin_in(tck_pin_in),
        .tms_pin_in(tms_pin_in), .cfg_error_in(cfg_error_in), .cfg_loaded_in(cfg_loaded_in),
        .scan_cell_instance_in(scan_cell_instance_in), .user_hi_out_in(user_hi_out_in),
        .user_hi_oe_in(user_hi_oe_in), .user_lo_out_in(user_lo_out_in),
        .user_lo_oe_in(user_lo_oe_in), .user_init_out_in(user_init_out_in),
        .user_init_oe_in(user_init_oe_in), .cfg_pending_hi_out(hi_o),
        .cfg_pending_hi_oe_out(hi_oe), .cfg_pending_lo_n_out(lo_o),
        .cfg_pending_lo_n_oe_out(lo_oe), .init_pin_out(init_o), .init_pin_oe_out(init_oe),
        .done_pin_out(done_o), .done_pin_oe_out(done_oe), .cfg_mode_out(mode_o),
        .master_mode_out(master_o), .config_run_out(run_o), .io_active_out(act_o),
        .scan_enable_out(scan_o), .tdi_user_out(tdi_o), .tck_user_out(tck_o),
        .tms_user_out(tms_o));

    csig_ctrl_model i_ctrl (.hold_init_in(hold_init), .hold_done_in(hold_done),
        .clear_req_in(clear_req), .dev_init_out_in(init_o), .dev_init_oe_in(init_oe),
        .dev_done_out_in(done_o), .dev_done_oe_in(done_oe), .init_wire_out(init_wire),
        .done_wire_out(done_wire), .clear_n_out(clear_n_pad));

    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // reporting
    task automatic end_of_test;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: sig = init_oe;
            1: sig = run_o;
            2: sig = done_oe;
            default: sig = act_o;
        endcase
    endfunction

    // counts falling edges until the watched output reaches v
    task automatic wait_lvl(input int k, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (sig(k) !== v) begin
            @(negedge clk_sys_in);
            cnt++;
            if (cnt > lim) begin
                chk(8'h00, 8'h01, "wait bound used up");
                end_of_test();
            end
        end
    endtask

    task automatic chk_range(input int v, input int lo, input int hi, input string msg);
        chk({7'h00, (v >= lo && v <= hi)}, 8'h01, msg);
    endtask

    // pending pins must agree with each other until user I/O take over
    always @(negedge clk_sys_in) begin
        if (!srst_in && act_o !== 1'b1 && (hi_o !== 1'b1 || lo_o !== 1'b0)) begin
            chk({6'h00, hi_o, lo_o}, 8'h02, "pending pins conflict");
        end
    end

    // ==========================================================
    // one full power-up per mode value
    initial begin
        void'($urandom(32'h494f7d2a));
        for (int m = 0; m < 8; m++) exp_modes.push_back(m);
        foreach (exp_modes[i]) begin
            @(negedge clk_sys_in);
            srst_in = 1'b1;
            hold_init = 1'b1;
            hold_done = 1'b1;
            scan_cell_instance_in = 1'($urandom);
            mode_select_in = exp_modes[i][2:0];
            repeat (5) @(negedge clk_sys_in);
            chk({hi_o, hi_oe, lo_o, lo_oe}, 8'h0d, "pending pins in reset");
            chk({done_o, init_o, init_oe, done_oe, act_o}, 8'h06, "init pulled in reset");
            srst_in = 1'b0;
            // power settle plus one clear pass plus the extra pass
            wait_lvl(0, 1'b0, 200, n);
            chk_range(n, 156, 166, "clear length to wait");
            repeat (40) @(negedge clk_sys_in);
            chk({run_o, init_wire}, 8'h00, "held in wait");
            hold_init = 1'b0;
            wait_lvl(1, 1'b1, 900, n);
            if (exp_modes[i][0] == 0) begin
                chk_range(n, 750, 760, "master wait extension");
            end else begin
                chk_range(n, 1, 8, "slave start delay");
            end
            chk({5'h00, mode_o}, {5'h00, exp_modes[i][2:0]}, "mode captured");
            chk({7'h00, master_o}, {7'h00, !exp_modes[i][0]}, "master flag");
            chk({scan_o, tdi_o, tck_o, tms_o}, 8'h08, "scan live while configuring");
            if (i == 5) begin
                // data error, sticky until a clear request
                cfg_error_in = 1'b1;
                @(negedge clk_sys_in);
                cfg_error_in = 1'b0;
                wait_lvl(0, 1'b1, 3, n);
                repeat (20) @(negedge clk_sys_in);
                chk({init_o, init_oe, init_wire, run_o}, 8'h04, "error pulls init");
                clear_req = 1'b1;
                repeat (10) @(negedge clk_sys_in);
                clear_req = 1'b0;
                wait_lvl(0, 1'b0, 200, n);
                chk_range(n, 64, 136, "finish pass plus one more");
                chk({7'h00, run_o}, 8'h00, "back in wait after clear");
            end else begin
                cfg_loaded_in = 1'b1;
                wait_lvl(2, 1'b0, 3, n);
                cfg_loaded_in = 1'b0;
                repeat (30) @(negedge clk_sys_in);
                chk({7'h00, act_o}, 8'h00, "done held low delays");
                // enable low must freeze the synchroniser and the sequencer alike
                ce_in = 1'b0;
                hold_done = 1'b0;
                repeat (10) @(negedge clk_sys_in);
                chk({6'h00, act_o, done_oe}, 8'h00, "frozen while enable low");
                ce_in = 1'b1;
                wait_lvl(3, 1'b1, 6, n);
                repeat (4) begin
                    u = 6'($urandom);
                    {user_hi_out_in, user_hi_oe_in, user_lo_out_in} = u[5:3];
                    {user_lo_oe_in, user_init_out_in, user_init_oe_in} = u[2:0];
                    {tdi_pin_in, tck_pin_in, tms_pin_in} = 3'($urandom);
                    repeat (2) @(negedge clk_sys_in);
                    chk({2'h0, hi_o, hi_oe, lo_o, lo_oe, 2'h0}, {2'h0, u[5:2], 2'h0},
                        "pending pins user");
                    chk({6'h00, init_o, init_oe}, {6'h00, u[1:0]}, "init pin user");
                    chk({7'h00, scan_o}, {7'h00, scan_cell_instance_in}, "scan off");
                    chk({5'h00, tdi_o, tck_o, tms_o},
                        scan_cell_instance_in ? 8'h00 : {5'h00, tdi_pin_in, tck_pin_in,
                        tms_pin_in}, "test pins user");
                end
            end
        end
        end_of_test();
    end
endmodule
